/* src/sri_top.sv */
// supervisor: two power-on reset outputs, intrusion latch and interrupt gate
`default_nettype none

// How it works
// - aux reset pulls low whenever the aux rail is under threshold.
// - aux reset stays low about 200 ms after the aux rail recovers.
// - both resets are active-low open drain; every assertion lasts 200 ms minimum.
// - primary reset pulls low whenever the primary rail is under threshold.
// - primary reset stays low about 200 ms after the primary rail recovers and aux reset has released.
// - primary reset releases only 200 ms after aux reset released.
// - primary reset pin is sensed as an external reset input while not driven.
// - a high intrusion input sets the chassis-intrusion flag.
// - intrusion flag stays set until cleared, held through main power loss.
// - interrupt output drives only when its enable is 1; enable defaults off.
// - interrupt output is open drain, pulling low only while signalling.

module sri_top
  import sri_pkg::*;
#(
  parameter int unsigned HOLD_TICK_COUNT = HOLD_TICKS,
  parameter int unsigned TICK_DIV        = TICK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic vbat_por,
  input  wire logic aux_rail_ok,
  input  wire logic primary_rail_ok,
  input  wire logic case_open_in,
  input  wire logic case_open_clear,
  input  wire logic irq_enable,
  input  wire logic irq_request,
  input  wire logic primary_supply_reset_n_in,
  output logic      aux_supply_reset_n_out,
  output logic      aux_supply_reset_n_oe,
  output logic      primary_supply_reset_n_out,
  output logic      primary_supply_reset_n_oe,
  output logic      irq_n_out,
  output logic      irq_n_oe,
  output logic      case_open_flag,
  output logic      ext_reset_seen
);

  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_chk_div
    $error("sri_top: TICK_DIV out of range");
  end
  if (HOLD_TICK_COUNT < 1) begin : g_chk_hold
    $error("sri_top: HOLD_TICK_COUNT must be at least 1");
  end

  // ==========================================================
  // internal oscillator: one-cycle tick every TICK_DIV clocks
  // ==========================================================
  localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic        tick;

  assign tick    = (div_r == DIV_LAST);
  assign div_nxt = tick ? 16'h0000 : div_r + 16'h0001;

  // free-running divider; the timers tolerate its arbitrary phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================
  // hold timers for both rails
  // ==========================================================
  logic aux_done;
  logic pri_done;
  logic pri_run;

  // primary hold only starts once the aux side has finished its own hold,
  // which puts a full hold time between the two releases
  assign pri_run = primary_rail_ok && aux_done;

  sri_hold_timer #(
    .TICKS (HOLD_TICK_COUNT)
  ) u_aux_timer (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick),
    .run  (aux_rail_ok),
    .done (aux_done)
  );

  sri_hold_timer #(
    .TICKS (HOLD_TICK_COUNT)
  ) u_pri_timer (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick),
    .run  (pri_run),
    .done (pri_done)
  );

  // ==========================================================
  // release sequencer
  // ==========================================================
  sri_seq_e seq_r;
  sri_seq_e seq_nxt;

  // aux must be released before primary can be; a dip on aux re-holds both
  always_comb begin
    case (seq_r)
      SEQ_BOTH_HELD: begin
        seq_nxt = aux_done ? SEQ_PRI_HELD : SEQ_BOTH_HELD;
      end
      SEQ_PRI_HELD: begin
        if (!aux_done) begin
          seq_nxt = SEQ_BOTH_HELD;
        end else if (pri_done) begin
          seq_nxt = SEQ_RUN;
        end else begin
          seq_nxt = SEQ_PRI_HELD;
        end
      end
      SEQ_RUN: begin
        if (!aux_done) begin
          seq_nxt = SEQ_BOTH_HELD;
        end else if (!pri_done) begin
          seq_nxt = SEQ_PRI_HELD;
        end else begin
          seq_nxt = SEQ_RUN;
        end
      end
      default: begin
        seq_nxt = SEQ_BOTH_HELD;
      end
    endcase
  end

  // sequencer state; reset holds both outputs asserted
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_r <= SEQ_BOTH_HELD;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // ==========================================================
  // open-drain reset pins
  // ==========================================================
  // the pads only ever pull low; release lets the board pull-up win
  assign aux_supply_reset_n_out     = OD_PULL_LEVEL;
  assign primary_supply_reset_n_out = OD_PULL_LEVEL;
  assign aux_supply_reset_n_oe      = (seq_r == SEQ_BOTH_HELD);
  assign primary_supply_reset_n_oe  = (seq_r != SEQ_RUN);

  // ==========================================================
  // external reset sensing on the primary reset pin
  // ==========================================================
  logic pri_oe_q_r;
  logic ext_seen_r;
  logic ext_seen_nxt;

  // ignore the pin during our own drive and the cycle after release,
  // so the slow rise through the pull-up is not mistaken for a request
  assign ext_seen_nxt = !primary_supply_reset_n_oe && !pri_oe_q_r &&
                        !primary_supply_reset_n_in;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pri_oe_q_r <= 1'b1;
      ext_seen_r <= 1'b0;
    end else begin
      pri_oe_q_r <= primary_supply_reset_n_oe;
      ext_seen_r <= ext_seen_nxt;
    end
  end

  assign ext_reset_seen = ext_seen_r;

  // ==========================================================
  // chassis-intrusion latch (battery domain)
  // ==========================================================
  logic case_flag_r;
  logic case_flag_nxt;

  // a set arriving with the clear wins, so no event is lost
  assign case_flag_nxt = case_open_in || (case_flag_r && !case_open_clear);

  // of the two resets only the battery power-on clears it; the system reset leaves it alone
  always_ff @(posedge mclk) begin
    if (vbat_por) begin
      case_flag_r <= FLAG_CLEAR;
    end else begin
      case_flag_r <= case_flag_nxt;
    end
  end

  assign case_open_flag = case_flag_r;

  // ==========================================================
  // interrupt output gate
  // ==========================================================
  logic irq_oe_r;
  logic irq_oe_nxt;

  assign irq_oe_nxt = irq_enable && (irq_request || case_flag_r);

  // enable input defaults low at reset through the system side, and the
  // output register starts released
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= irq_oe_nxt;
    end
  end

  assign irq_n_out = OD_PULL_LEVEL;
  assign irq_n_oe  = irq_oe_r;

  // ==========================================================
  // checks
  // ==========================================================
  localparam int unsigned HOLD_CYC = HOLD_TICK_COUNT * TICK_DIV;

  int unsigned aux_up_cnt;
  int unsigned pri_up_cnt;
  int unsigned aux_rel_cnt;

  // cycles each rail has been good and aux reset has been released
  always_ff @(posedge mclk) begin
    if (rst) begin
      aux_up_cnt  <= 0;
      pri_up_cnt  <= 0;
      aux_rel_cnt <= 0;
    end else begin
      aux_up_cnt  <= !aux_rail_ok ? 0 : (aux_up_cnt == 32'hffffffff ? aux_up_cnt : aux_up_cnt + 1);
      pri_up_cnt  <= !primary_rail_ok ? 0 : (pri_up_cnt == 32'hffffffff ? pri_up_cnt : pri_up_cnt + 1);
      aux_rel_cnt <= aux_supply_reset_n_oe ? 0 :
                     (aux_rel_cnt == 32'hffffffff ? aux_rel_cnt : aux_rel_cnt + 1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_aux_low_hold: assert property (!aux_rail_ok |-> ##2 aux_supply_reset_n_oe)
    else $error("aux reset not asserted while aux rail low");

  a_aux_min_pulse: assert property ($fell(aux_supply_reset_n_oe) |-> aux_up_cnt >= HOLD_CYC)
    else $error("aux reset released before hold time");

  a_pri_low_hold: assert property (!primary_rail_ok |-> ##2 primary_supply_reset_n_oe)
    else $error("primary reset not asserted while primary rail low");

  a_pri_min_pulse: assert property ($fell(primary_supply_reset_n_oe) |-> pri_up_cnt >= HOLD_CYC)
    else $error("primary reset released before hold time");

  a_pri_after_aux: assert property ($fell(primary_supply_reset_n_oe) |-> aux_rel_cnt >= HOLD_CYC)
    else $error("primary reset released too soon after aux");

  a_od_levels: assert property ((aux_supply_reset_n_oe || primary_supply_reset_n_oe || irq_n_oe)
                                |-> !(aux_supply_reset_n_out || primary_supply_reset_n_out || irq_n_out))
    else $error("open-drain pin driven high");

  a_ext_sense: assert property (!primary_supply_reset_n_oe && !$past(primary_supply_reset_n_oe)
                                && !primary_supply_reset_n_in |=> ext_reset_seen)
    else $error("external reset on primary pin not sensed");

  a_case_set: assert property (disable iff (vbat_por) case_open_in |=> case_open_flag)
    else $error("intrusion input did not set flag");

  a_case_keep: assert property (disable iff (vbat_por)
                                case_open_flag && !case_open_clear |=> case_open_flag)
    else $error("intrusion flag lost without clear");

  a_irq_gate: assert property (!irq_enable |=> !irq_n_oe)
    else $error("interrupt driven while disabled");

  a_irq_fire: assert property (irq_enable && irq_request |=> irq_n_oe ##0 !irq_n_out)
    else $error("interrupt not signalled");

  a_hold_restart: assert property ($fell(aux_rail_ok) |=> !aux_done [*2])
    else $error("aux hold timer not restarted on dip");

  // release order, quiet window and clear paths; cheap guards on the decode
  a_pri_order: assert property (!primary_supply_reset_n_oe |-> !aux_supply_reset_n_oe)
    else $error("primary reset released while aux reset held");

  a_ext_quiet: assert property (primary_supply_reset_n_oe |=> !ext_reset_seen)
    else $error("own primary reset drive taken as external reset");

  a_case_clear: assert property (case_open_clear && !case_open_in |=> !case_open_flag)
    else $error("intrusion flag not cleared by clear");

  a_vbat_clear: assert property (vbat_por |=> !case_open_flag)
    else $error("intrusion flag survived battery clear");

  a_irq_release: assert property (irq_enable && !irq_request && !case_open_flag |=> !irq_n_oe)
    else $error("interrupt driven with no source");

endmodule

`default_nettype wire

/* src/sri_pkg.sv */
// shared constants and types of the supervisor / reset / intrusion block
`default_nettype none

package sri_pkg;

  // ==========================================================
  // clock and internal oscillator
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_NS  = 1000;   // internal oscillator period
  // a least time: round up to whole clock cycles
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // reset hold time
  // ==========================================================
  localparam int unsigned HOLD_TIME_MS  = 200;
  localparam int unsigned NS_PER_MS     = 1000000;
  // a least time: round up to whole oscillator ticks
  localparam int unsigned HOLD_TICKS    = (HOLD_TIME_MS * NS_PER_MS + TICK_TIME_NS - 1) / TICK_TIME_NS;

  // ==========================================================
  // pin levels and sequencer states
  // ==========================================================
  localparam logic OD_PULL_LEVEL = 1'b0;   // open-drain pins only ever pull low
  localparam logic FLAG_CLEAR    = 1'b0;   // reset value of the intrusion flag

  typedef enum logic [1:0] {
    SEQ_BOTH_HELD,
    SEQ_PRI_HELD,
    SEQ_RUN
  } sri_seq_e;

endpackage

`default_nettype wire

/* src/sri_hold_timer.sv */
// restartable hold-off timer counted in oscillator ticks
`default_nettype none

module sri_hold_timer
  import sri_pkg::*;
#(
  parameter int unsigned TICKS = HOLD_TICKS
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic run,
  output logic      done
);

  localparam int unsigned CW = $clog2(TICKS + 2);
  // one extra tick is counted because the first one after start may be partial
  localparam logic [CW-1:0] LAST = CW'(TICKS);

  if (TICKS < 1) begin : g_chk
    $error("sri_hold_timer: TICKS must be at least 1");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          done_r;
  logic          done_nxt;

  // ==========================================================
  // count while run stays high, restart whenever it drops
  // ==========================================================
  assign cnt_nxt  = (!run) ? '0 :
                    (tick && !done_r) ? cnt_r + CW'(1) : cnt_r;
  assign done_nxt = run && (done_r || (tick && cnt_r == LAST));

  // state registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

endmodule

`default_nettype wire

/* bench/sri_host_model.sv */
// host-side model: pulled-up reset and interrupt wires with an external reset driver
`default_nettype none

module sri_host_model (
  input  wire logic aux_oe,
  input  wire logic aux_out,
  input  wire logic pri_oe,
  input  wire logic pri_out,
  input  wire logic irq_oe,
  input  wire logic irq_out,
  input  wire logic ext_pull,
  output logic      aux_n,
  output logic      pri_n,
  output logic      irq_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // wire resolution
  // ==========================================================
  // board pull-ups: a released line reads high, never the last driven value
  // a driven line shows the pad's data, so a pad that drove high would be seen
  assign aux_n = aux_oe ? aux_out : 1'h1;
  // host logic may pull the primary line too, so it is wired-and
  assign pri_n = ext_pull ? 1'h0 : (pri_oe ? pri_out : 1'h1);
  assign irq_n = irq_oe ? irq_out : 1'h1;
endmodule

`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the supervisor block with a pulled-up host model
`default_nettype none

module testbench;
  import sri_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // short hold for simulation; bounds allow the partial first tick and pipeline
  localparam int unsigned HT = 4;
  localparam int unsigned TD = 2;
  localparam int          LO = HT * TD;
  localparam int          HI = (HT + 1) * TD + 3;

  logic mclk, rst, vbat_por, aux_ok, pri_ok, case_in, case_clr;
  logic irq_en, irq_req, ext_pull;
  logic aux_oe, pri_oe, irq_oe, aux_n, pri_n, irq_n, flag, ext_seen;
  logic aux_do, pri_do, irq_do;
  int   num_errors, num_checks, cyc;

  sri_top #(.HOLD_TICK_COUNT(HT), .TICK_DIV(TD)) u_sri_top (
    .mclk(mclk), .rst(rst), .vbat_por(vbat_por), .aux_rail_ok(aux_ok),
    .primary_rail_ok(pri_ok), .case_open_in(case_in), .case_open_clear(case_clr),
    .irq_enable(irq_en), .irq_request(irq_req), .primary_supply_reset_n_in(pri_n),
    .aux_supply_reset_n_out(aux_do), .aux_supply_reset_n_oe(aux_oe),
    .primary_supply_reset_n_out(pri_do), .primary_supply_reset_n_oe(pri_oe),
    .irq_n_out(irq_do), .irq_n_oe(irq_oe), .case_open_flag(flag), .ext_reset_seen(ext_seen));

  sri_host_model u_sri_host_model (
    .aux_oe(aux_oe), .aux_out(aux_do), .pri_oe(pri_oe), .pri_out(pri_do),
    .irq_oe(irq_oe), .irq_out(irq_do), .ext_pull(ext_pull),
    .aux_n(aux_n), .pri_n(pri_n), .irq_n(irq_n));

  // ==========================================================
  // clock, timeout and shared tasks
  // ==========================================================
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // a hung wait must still reach the verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("ERROR timeout expected finish seen hang");
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // counts cycles until a reset wire releases, then checks the hold length
  task automatic rel_chk(input bit prim, input string what);
    int n;
    n = 0;
    while (((prim ? pri_n : aux_n) !== 1'h1) && n < 60) begin
      step(1);
      n++;
    end
    num_checks++;
    if (n < LO || n > HI) begin
      num_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, LO, HI, n);
    end
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    chk("aux held", 1'h0, aux_n);
    chk("pri held", 1'h0, pri_n);
    chk("irq idle", 1'h1, irq_n);
    chk("flag idle", 1'h0, flag);
    chk("ext idle", 1'h0, ext_seen);
  endtask

  task automatic t_intr();
    case_in = 1'h1;
    step(1);
    chk("flag set", 1'h1, flag);
    case_in = 1'h0;
    step(3);
    chk("flag kept", 1'h1, flag);
    rst = 1'h1;
    step(1);
    rst = 1'h0;
    step(1);
    chk("flag past rst", 1'h1, flag);
    vbat_por = 1'h1;
    step(1);
    vbat_por = 1'h0;
    chk("flag vbat clr", 1'h0, flag);
    case_in = 1'h1;
    case_clr = 1'h1;
    step(2);
    chk("set wins", 1'h1, flag);
    case_in = 1'h0;
    step(1);
    case_clr = 1'h0;
    step(1);
    chk("flag cleared", 1'h0, flag);
  endtask

  task automatic t_irq();
    irq_req = 1'h1;
    step(3);
    chk("irq gated", 1'h1, irq_n);
    irq_en = 1'h1;
    step(3);
    chk("irq pulled", 1'h0, irq_n);
    irq_req = 1'h0;
    step(3);
    chk("irq released", 1'h1, irq_n);
    case_in = 1'h1;
    step(1);
    case_in = 1'h0;
    step(3);
    chk("irq by flag", 1'h0, irq_n);
    case_clr = 1'h1;
    step(1);
    case_clr = 1'h0;
    step(3);
    chk("irq flag clr", 1'h1, irq_n);
    irq_en = 1'h0;
  endtask

  // rails rise together, aux dips mid-count so its timer restarts
  task automatic t_power();
    aux_ok = 1'h1;
    pri_ok = 1'h1;
    step(LO / 2);
    aux_ok = 1'h0;
    step(1);
    aux_ok = 1'h1;
    rel_chk(1'b0, "aux hold");
    chk("pri after aux", 1'h0, pri_n);
    rel_chk(1'b1, "pri hold");
  endtask

  // one-cycle dips still give a full-length pulse
  task automatic t_dips();
    aux_ok = 1'h0;
    step(1);
    aux_ok = 1'h1;
    step(1);
    chk("aux dip", 1'h0, aux_n);
    chk("pri by aux", 1'h0, pri_n);
    rel_chk(1'b0, "aux dip hold");
    rel_chk(1'b1, "pri re-hold");
    pri_ok = 1'h0;
    step(1);
    pri_ok = 1'h1;
    step(1);
    chk("pri dip", 1'h0, pri_n);
    chk("aux stays", 1'h1, aux_n);
    rel_chk(1'b1, "pri dip hold");
  endtask

  task automatic t_ext();
    step(2);
    ext_pull = 1'h1;
    step(2);
    chk("ext seen", 1'h1, ext_seen);
    chk("aux free", 1'h1, aux_n);
    ext_pull = 1'h0;
    step(2);
    chk("ext gone", 1'h0, ext_seen);
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {rst, vbat_por} = 2'h3;
    {aux_ok, pri_ok, case_in, case_clr, irq_en, irq_req, ext_pull} = 7'h00;
    {num_errors, num_checks, cyc} = '0;
    step(4);
    {rst, vbat_por} = 2'h0;
    step(1);
    t_reset();
    t_intr();
    t_irq();
    t_power();
    t_dips();
    t_ext();
    close_out();
  end
endmodule

`default_nettype wire
